//--- hdl/fdig_glue.sv
// Notes on behaviour
// - Controller clock 8 MHz large, 4 MHz small.
// - Read clock follows controller and drive size.
// - Write clock follows controller and drive size.
// - Write data counts only under write gate.
// - Density mode picks MFM or FM clocks.
// - Two unit bits decode to four selects.
// - Ready forced true for readyless small drives.
// - Strap picks forced or drive ready.
// - Seek mode switches all shared selectors.
// - Shared output becomes fault reset or step.
// - Shared output becomes low current or direction.
// - One step pulse moves one cylinder.
// - Direction low outward, high inward.
// - Low current goes to large drives.
// - Shared input: write protect or two sided.
// - Shared input: fault or track zero.
// - Read data resynchronised to the oscillator.
// - Data window generated for the controller.
// - Load pulse resyncs window counter to data.
// - Oscillator control steers the data separator.
// - Head load and side select pass to cable.
// - Transfer request passed toward the DMA.
// - Small drives halve controller clocks.
// - Drive size flip-flop, software set if strapped.
`timescale 1ns/100ps
module fdig_glue
(
    input wire logic ref_clk,
    input wire logic rst,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Board straps.
    input wire logic strap_sw_size_en,
    input wire logic strap_mini,
    input wire logic strap_force_ready,
    // Disk controller side.
    input wire fdig_pkg::fdig_ctl_out_t ctl_out,
    output fdig_pkg::fdig_ctl_in_t ctl_in,
    output logic dma_request,
    // Drive cable side.
    input wire fdig_pkg::fdig_drv_in_t drv_in,
    output fdig_pkg::fdig_drv_out_t drv_out
);
    import fdig_pkg::*;

    logic mini_r;
    logic [NCO_W-1:0] nco_r;
    logic [NCO_W:0] nco_sum;
    logic base_en;
    logic [DIV_W-1:0] div_r;
    logic [2:0] tap_ctl;
    logic [2:0] tap_wr;
    logic [2:0] tap_rd;
    logic rd_prev_r;
    logic rd_edge;
    logic [WIN_W-1:0] win_cnt_r;
    logic [WIN_W-1:0] win_len;
    logic [WIN_W-1:0] win_half;
    logic win_r;
    logic wb_req;
    logic [31:0] status_word;

    // A request is answered once; ack falls the cycle after it was given.
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    // Drive size flip-flop: software owns it only when the strap allows,
    // otherwise it tracks the board strap after reset is released.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            mini_r <= CTRL_MINI_RST;
        else if (!strap_sw_size_en)
            mini_r <= strap_mini;
        else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL)
            mini_r <= wb_dat_i[CTRL_MINI_BIT];
    end

    // Status shows the block's live state for software.
    always_comb
    begin
        status_word = 32'h0;
        status_word[ST_MINI_BIT] = mini_r;
        status_word[ST_READY_BIT] = ctl_in.ready;
        status_word[ST_SEEK_BIT] = ctl_out.seek_mode;
        status_word[ST_MFM_BIT] = ctl_out.mfm_mode;
        status_word[ST_SWEN_BIT] = strap_sw_size_en;
        status_word[ST_UNIT_LSB] = ctl_out.unit_select_bit_low;
        status_word[ST_UNIT_LSB+1] = ctl_out.unit_select_bit_high;
    end

    // Read data is latched with ack; unmapped offsets read as zero.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wb_dat_o <= 32'h0;
        else if (wb_req && !wb_we_i)
            unique case (wb_adr_i)
                OFS_CTRL: wb_dat_o <= {31'h0, mini_r};
                OFS_STATUS: wb_dat_o <= status_word;
                default: wb_dat_o <= 32'h0;
            endcase
    end

    // 16 MHz enable from the 50 MHz clock by phase accumulation; the
    // edges jitter by one reference period, which the controller tolerates
    // better than a clock derived from a second oscillator domain.
    assign nco_sum = {1'b0, nco_r} + {1'b0, NCO_INC};
    assign base_en = nco_sum[NCO_W];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            nco_r <= '0;
        else
            nco_r <= nco_sum[NCO_W-1:0];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            div_r <= '0;
        else if (base_en)
            div_r <= div_r + 1'b1;
    end

    // Tap choice: small drives move every clock one tap slower, and
    // single density moves the data clocks one more tap slower.
    always_comb
    begin
        tap_ctl = TAP_CTL_LARGE + {2'b00, mini_r};
        tap_wr = TAP_WR_MFM_LARGE + {2'b00, mini_r}
            + {2'b00, !ctl_out.mfm_mode};
        tap_rd = tap_wr - 3'h1;
    end

    // Clock outputs are registered taps of the divider.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_in.ctl_clock <= 1'b0;
            ctl_in.write_clock <= 1'b0;
            ctl_in.read_clock <= 1'b0;
        end
        else
        begin
            ctl_in.ctl_clock <= div_r[tap_ctl];
            ctl_in.write_clock <= div_r[tap_wr];
            ctl_in.read_clock <= div_r[tap_rd];
        end
    end

    // Window length is half a data cell; it doubles for FM and for small
    // drives so the window always brackets one clock or one data bit.
    always_comb
    begin
        win_len = WIN_W'(WINDOW_CYC);
        if (!ctl_out.mfm_mode)
            win_len = win_len << 1;
        if (mini_r)
            win_len = win_len << 1;
        win_half = win_len >> 1;
    end

    assign rd_edge = drv_in.read_data && !rd_prev_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rd_prev_r <= 1'b0;
        else
            rd_prev_r <= drv_in.read_data;
    end

    // Window counter free-runs; a read pulse reloads it to mid-window so
    // transitions sit centred, but only while the oscillator is steered.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            win_cnt_r <= '0;
            win_r <= 1'b0;
        end
        else if (rd_edge && ctl_out.vco_enable)
            win_cnt_r <= win_half;
        else if (win_cnt_r >= win_len - 1'b1)
        begin
            win_cnt_r <= '0;
            win_r <= !win_r;
        end
        else
            win_cnt_r <= win_cnt_r + 1'b1;
    end

    // Read path toward the controller.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_in.read_data <= 1'b0;
            ctl_in.data_window <= 1'b0;
            ctl_in.window_counter_load <= 1'b0;
        end
        else
        begin
            ctl_in.read_data <= rd_edge;
            ctl_in.data_window <= win_r;
            ctl_in.window_counter_load <=
                rd_edge && ctl_out.vco_enable;
        end
    end

    // Shared status inputs to the controller and ready.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_in.protect_or_double_side <= 1'b0;
            ctl_in.fault_or_track_zero <= 1'b0;
            ctl_in.ready <= 1'b0;
        end
        else
        begin
            ctl_in.protect_or_double_side <= ctl_out.seek_mode
                ? drv_in.two_sided : drv_in.write_protect;
            ctl_in.fault_or_track_zero <= ctl_out.seek_mode
                ? drv_in.track_zero : drv_in.fault;
            ctl_in.ready <= strap_force_ready
                ? 1'b1 : drv_in.ready;
        end
    end

    // Shared controller outputs split by seek mode; the inactive meaning
    // is held low so a drive never sees a stray step or fault reset.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            drv_out.step <= 1'b0;
            drv_out.direction <= 1'b0;
            drv_out.fault_reset <= 1'b0;
            drv_out.low_current <= 1'b0;
        end
        else
        begin
            drv_out.step <= ctl_out.seek_mode
                && ctl_out.fault_reset_or_step;
            drv_out.direction <= ctl_out.seek_mode
                && ctl_out.low_current_or_direction;
            drv_out.fault_reset <= !ctl_out.seek_mode
                && ctl_out.fault_reset_or_step;
            drv_out.low_current <= !ctl_out.seek_mode && !mini_r
                && ctl_out.low_current_or_direction;
        end
    end

    // Drive selects: one-hot decode of the unit bits.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sel
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    drv_out.drive_select[g] <= 1'b0;
                else
                    drv_out.drive_select[g] <= {ctl_out.unit_select_bit_high,
                        ctl_out.unit_select_bit_low} == 2'(g);
            end
        end
    endgenerate

    // Pass-through controls, write data masked outside the write gate.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            drv_out.head_load <= 1'b0;
            drv_out.side_select <= 1'b0;
            drv_out.write_gate <= 1'b0;
            drv_out.write_data <= 1'b0;
            dma_request <= 1'b0;
        end
        else
        begin
            drv_out.head_load <= ctl_out.head_load;
            drv_out.side_select <= ctl_out.side_select;
            drv_out.write_gate <= ctl_out.write_gate;
            drv_out.write_data <= ctl_out.write_gate
                && ctl_out.write_data;
            dma_request <= ctl_out.disk_transfer_request;
        end
    end

endmodule : fdig_glue

//--- hdl/fdig_pkg.sv
package fdig_pkg;

    // Board clock and the fast reference that the floppy clocks divide from.
    localparam int REF_CLK_HZ = 50_000_000;
    localparam int BASE_HZ = 16_000_000;
    localparam int NCO_W = 16;
    localparam logic [NCO_W-1:0] NCO_INC =
        NCO_W'((longint'(BASE_HZ) << NCO_W) / REF_CLK_HZ);

    // Divider taps off the 16 MHz base count; a tap n toggles at 16/2^(n+1).
    localparam int DIV_W = 8;
    localparam logic [2:0] TAP_CTL_LARGE = 3'h0;
    localparam logic [2:0] TAP_WR_MFM_LARGE = 3'h4;

    // Half a data cell for double density on large drives, in ns.
    localparam int WINDOW_NS = 1000;
    localparam int WINDOW_CYC = (WINDOW_NS * (REF_CLK_HZ / 1_000_000)) / 1000;
    localparam int WIN_W = 10;

    // Register offsets on the bus, byte addresses.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;

    // Control register fields.
    localparam int CTRL_MINI_BIT = 0;
    localparam logic CTRL_MINI_RST = 1'b0;

    // Status register fields.
    localparam int ST_MINI_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_SEEK_BIT = 2;
    localparam int ST_MFM_BIT = 3;
    localparam int ST_SWEN_BIT = 4;
    localparam int ST_UNIT_LSB = 8;

    // Signals the disk controller drives toward the glue.
    typedef struct packed {
        logic seek_mode;
        logic fault_reset_or_step;
        logic low_current_or_direction;
        logic head_load;
        logic side_select;
        logic unit_select_bit_low;
        logic unit_select_bit_high;
        logic write_data;
        logic write_gate;
        logic mfm_mode;
        logic vco_enable;
        logic disk_transfer_request;
    } fdig_ctl_out_t;

    // Signals the glue returns to the disk controller.
    typedef struct packed {
        logic ctl_clock;
        logic write_clock;
        logic read_clock;
        logic ready;
        logic protect_or_double_side;
        logic fault_or_track_zero;
        logic read_data;
        logic data_window;
        logic window_counter_load;
    } fdig_ctl_in_t;

    // Lines coming up the drive cable.
    typedef struct packed {
        logic ready;
        logic write_protect;
        logic two_sided;
        logic fault;
        logic track_zero;
        logic read_data;
    } fdig_drv_in_t;

    // Lines going down the drive cable.
    typedef struct packed {
        logic step;
        logic direction;
        logic fault_reset;
        logic low_current;
        logic head_load;
        logic side_select;
        logic [3:0] drive_select;
        logic write_data;
        logic write_gate;
    } fdig_drv_out_t;

endpackage : fdig_pkg

//--- test/fdig_drive_model.sv
`timescale 1ns/100ps
module fdig_drive_model
(
    input wire logic ref_clk,
    input wire fdig_pkg::fdig_drv_out_t drv_out,
    output fdig_pkg::fdig_drv_in_t drv_in,
    output int cylinder
);
    import fdig_pkg::*;
    logic step_d = 1'b0;
    int rd_cnt = 0;
    initial cylinder = 5;

    // Head moves one cylinder per step edge, inward on a high line.
    always @(posedge ref_clk)
    begin
        step_d <= drv_out.step;
        if (drv_out.step && !step_d)
            cylinder <= drv_out.direction ? cylinder + 1 :
                (cylinder > 0 ? cylinder - 1 : 0);
        rd_cnt <= (rd_cnt == 99) ? 0 : rd_cnt + 1;
    end

    // Write data is never looked at, so an ungated bit cannot land.
    // Ready and read data come back only while the head is loaded.
    always_comb
    begin
        drv_in.ready = drv_out.head_load;
        drv_in.write_protect = 1'b1;
        drv_in.two_sided = 1'b0;
        drv_in.fault = 1'b0;
        drv_in.track_zero = (cylinder == 0);
        drv_in.read_data = drv_out.head_load && rd_cnt < 3;
    end
endmodule : fdig_drive_model

//--- test/fdig_props.sv
`timescale 1ns/100ps
module fdig_props
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic strap_force_ready,
    input wire fdig_pkg::fdig_ctl_out_t ctl_out,
    input wire fdig_pkg::fdig_ctl_in_t ctl_in,
    input wire logic dma_request,
    input wire fdig_pkg::fdig_drv_in_t drv_in,
    input wire fdig_pkg::fdig_drv_out_t drv_out
);
    import fdig_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // A read edge while the oscillator runs must reload the window.
    sequence s_rd_edge;
        ctl_out.vco_enable && $rose(drv_in.read_data);
    endsequence
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    property p_step;
        1 |=> drv_out.step ==
            $past(ctl_out.seek_mode & ctl_out.fault_reset_or_step);
    endproperty
    a_step: assert property (p_step) else $error("step wrong");
    property p_dir;
        1 |=> drv_out.direction ==
            $past(ctl_out.seek_mode & ctl_out.low_current_or_direction);
    endproperty
    a_dir: assert property (p_dir) else $error("dir wrong");
    property p_frst;
        1 |=> drv_out.fault_reset ==
            $past(!ctl_out.seek_mode & ctl_out.fault_reset_or_step);
    endproperty
    a_frst: assert property (p_frst) else $error("frst wrong");
    property p_sel;
        1 |=> drv_out.drive_select == 4'h1 << $past(
            {ctl_out.unit_select_bit_high, ctl_out.unit_select_bit_low});
    endproperty
    a_sel: assert property (p_sel) else $error("select wrong");
    property p_pods;
        1 |=> ctl_in.protect_or_double_side == $past(ctl_out.seek_mode ?
            drv_in.two_sided : drv_in.write_protect);
    endproperty
    a_pods: assert property (p_pods) else $error("pods wrong");
    property p_ftz;
        1 |=> ctl_in.fault_or_track_zero == $past(ctl_out.seek_mode ?
            drv_in.track_zero : drv_in.fault);
    endproperty
    a_ftz: assert property (p_ftz) else $error("ftz wrong");
    property p_wd;
        1 |=> drv_out.write_data ==
            $past(ctl_out.write_data & ctl_out.write_gate);
    endproperty
    a_wd: assert property (p_wd) else $error("wdata wrong");
    property p_rdy;
        strap_force_ready |=> ctl_in.ready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready wrong");
    property p_dma;
        1 |=> dma_request == $past(ctl_out.disk_transfer_request);
    endproperty
    a_dma: assert property (p_dma) else $error("dma wrong");
    property p_load;
        s_rd_edge |-> ##[1:3] ctl_in.window_counter_load;
    endproperty
    a_load: assert property (p_load) else $error("no load");
    property p_ack;
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack wrong");
endmodule : fdig_props

bind fdig_glue fdig_props i_props (.ref_clk(ref_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .strap_force_ready(strap_force_ready), .ctl_out(ctl_out),
    .ctl_in(ctl_in), .dma_request(dma_request), .drv_in(drv_in),
    .drv_out(drv_out));

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import fdig_pkg::*;
    logic ref_clk = 0;
    logic rst = 1;
    logic cyc = 0, stb = 0, we = 0, ack, dma;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rdo, rdat;
    logic sw_en = 0, force_rdy = 0;
    fdig_ctl_out_t co = '0;
    fdig_ctl_in_t ci;
    fdig_drv_in_t di;
    fdig_drv_out_t dro;
    int cyl, n_fail = 0, n_compared = 0, cyc_cnt = 0, x, k, r, w;
    logic dw;
    int e[3];

    always #10 ref_clk = ~ref_clk;

    fdig_glue i_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
        .strap_sw_size_en(sw_en), .strap_mini(1'b0),
        .strap_force_ready(force_rdy), .ctl_out(co), .ctl_in(ci),
        .dma_request(dma), .drv_in(di), .drv_out(dro));
    fdig_drive_model i_drv (.ref_clk(ref_clk), .drv_out(dro),
        .drv_in(di), .cylinder(cyl));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // Hangs are cut here after 40000 cycles; bus waits also time out in wb.
    always @(posedge ref_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 40000)
        begin
            n_fail++;
            stop_test;
        end
    end

    // One classic bus cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        we <= w;
        adr <= a;
        dat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rdat = rdo;
        // A slave that never answers ends the run at once.
        if (n >= 50)
        begin
            n_fail++;
            stop_test;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb

    // Counts rising edges of the three clocks over 40 us.
    task automatic meas;
        logic [2:0] p, c;
        e = '{0, 0, 0};
        p = {ci.ctl_clock, ci.write_clock, ci.read_clock};
        repeat (2000)
        begin
            @(posedge ref_clk);
            c = {ci.ctl_clock, ci.write_clock, ci.read_clock};
            for (int i = 0; i < 3; i++)
                e[i] += int'(c[i] && !p[i]);
            p = c;
        end
    endtask : meas

    task automatic step;
        co.fault_reset_or_step <= 1'b1;
        @(posedge ref_clk);
        co.fault_reset_or_step <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : step

    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        wb(0, OFS_CTRL, 0);
        check(rdat, 0);
        wb(1, 4'h8, 32'hffffffff);
        wb(0, 4'h8, 0);
        check(rdat, 0);
        sw_en <= 1'b1;
        $display("test registers end");
        // Sizes and densities: large MFM, large FM, small MFM.
        for (int m = 0; m < 3; m++)
        begin
            co.mfm_mode <= (m != 1);
            wb(1, OFS_CTRL, 32'(m == 2));
            meas;
            x = 20 >> ((m == 1) + (m == 2));
            check(e[2] inside {[((m == 2) ? 159 : 319) :
                ((m == 2) ? 161 : 321)]}, 1);
            check(e[1] inside {[x - 1 : x + 1]}, 1);
            check(e[0] inside {[2 * x - 1 : 2 * x + 1]}, 1);
            wb(0, OFS_STATUS, 0);
            check(rdat[ST_MINI_BIT], m == 2);
        end
        $display("test clocks end");
        for (int u = 0; u < 4; u++)
        begin
            {co.unit_select_bit_high, co.unit_select_bit_low} <= u[1:0];
            repeat (3) @(posedge ref_clk);
            check(dro.drive_select, 4'h1 << u);
        end
        co.seek_mode <= 1'b1;
        co.head_load <= 1'b1;
        co.low_current_or_direction <= 1'b1;
        repeat (3) step;
        check(cyl, 8);
        co.low_current_or_direction <= 1'b0;
        repeat (8) step;
        check(cyl, 0);
        check(ci.fault_or_track_zero, 1);
        check(ci.protect_or_double_side, 0);
        wb(1, OFS_CTRL, 0);
        co.seek_mode <= 1'b0;
        co.fault_reset_or_step <= 1'b1;
        co.low_current_or_direction <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({dro.fault_reset, dro.low_current, dro.step, dro.direction},
            4'hc);
        check({ci.protect_or_double_side, ci.fault_or_track_zero}, 2);
        $display("test seek end");
        co.write_data <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(dro.write_data, 0);
        co.write_gate <= 1'b1;
        co.side_select <= 1'b1;
        co.disk_transfer_request <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({dro.write_data, dro.head_load, dro.side_select, dma},
            4'hf);
        co.head_load <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(ci.ready, 0);
        force_rdy <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(ci.ready, 1);
        co.head_load <= 1'b1;
        co.vco_enable <= 1'b1;
        k = 0;
        r = 0;
        w = 0;
        dw = ci.data_window;
        // The window must keep toggling between reloads, not stick.
        repeat (300)
        begin
            @(posedge ref_clk);
            k += int'(ci.window_counter_load === 1'b1);
            r += int'(ci.read_data === 1'b1);
            w += int'(ci.data_window !== dw);
            dw = ci.data_window;
        end
        check(w inside {[4:8]}, 1);
        check(k inside {[2:3]}, 1);
        check(r inside {[2:3]}, 1);
        $display("test data path end");
        stop_test;
    end
endmodule : tb_top
